/* File: pkg/nbx_pkg.sv */
package nbx_pkg;

	// datapath widths
	localparam int NIB_W   = 4;
	localparam int X_W     = 2;
	localparam int PC_W    = 6;
	localparam int PAGE_W  = 4;
	localparam int BLOCK_W = 2;
	localparam int RAM_AW  = X_W + NIB_W;
	localparam int STACK_D = 3;

	// reset values
	localparam logic [NIB_W-1:0]   RST_NIB   = 4'h0;
	localparam logic [X_W-1:0]     RST_X     = 2'h0;
	localparam logic [PAGE_W-1:0]  RST_PAGE  = 4'h0;
	localparam logic [BLOCK_W-1:0] RST_BLOCK = 2'h0;
	localparam logic               RST_FLAG  = 1'h1;

	// field positions of the instruction byte
	localparam int F4_HI = 7;
	localparam int F4_LO = 6;
	localparam int F3_HI = 7;
	localparam int F3_LO = 4;
	localparam int F2_HI = 7;
	localparam int F2_LO = 2;

	// format iv prefixes (bits 7:6), operand 6 bits
	localparam logic [1:0] OP4_JUMP = 2'h2;
	localparam logic [1:0] OP4_CALL = 2'h3;
	// format iii prefixes (bits 7:4), operand 4 bits
	localparam logic [3:0] OP3_LOAD_Y     = 4'h4;
	localparam logic [3:0] OP3_STORE_STEP = 4'h5;
	localparam logic [3:0] OP3_SET_PAGE   = 4'h6;
	// format ii prefixes (bits 7:2), operand 2 bits, bits 7 and 6 zero
	localparam logic [5:0] OP2_LOAD_X  = 6'h08;
	localparam logic [5:0] OP2_SET_BIT = 6'h09;
	localparam logic [5:0] OP2_CLR_BIT = 6'h0a;
	localparam logic [5:0] OP2_TST_BIT = 6'h0b;
	// format i full opcodes
	localparam logic [7:0] OP1_COPY_Y_TO_ACC   = 8'h00;
	localparam logic [7:0] OP1_COPY_ACC_TO_Y   = 8'h01;
	localparam logic [7:0] OP1_CLEAR_ACC       = 8'h02;
	localparam logic [7:0] OP1_STORE_ACC       = 8'h03;
	localparam logic [7:0] OP1_STORE_ACC_STEP  = 8'h04;
	localparam logic [7:0] OP1_LOAD_Y_FROM_RAM = 8'h05;
	localparam logic [7:0] OP1_LOAD_ACC_RAM    = 8'h06;
	localparam logic [7:0] OP1_SWAP_ACC_RAM    = 8'h07;
	localparam logic [7:0] OP1_RETURN          = 8'h08;
	localparam logic [7:0] OP1_SET_BLOCK_Y     = 8'h09;
	localparam logic [7:0] OP1_TABLE_READ      = 8'h0a;

	// full rom address: block, page, word
	typedef struct packed {
		logic [BLOCK_W-1:0] block;
		logic [PAGE_W-1:0]  page;
		logic [PC_W-1:0]    pc;
	} nbx_addr_t;

	typedef enum logic [4:0] {
		OP_NOP            = 5'b00000,
		OP_COPY_Y_TO_ACC  = 5'b00001,
		OP_COPY_ACC_TO_Y  = 5'b00010,
		OP_CLEAR_ACC      = 5'b00011,
		OP_STORE_ACC      = 5'b00100,
		OP_STORE_ACC_STEP = 5'b00101,
		OP_LOAD_Y_RAM     = 5'b00110,
		OP_LOAD_ACC_RAM   = 5'b00111,
		OP_SWAP_ACC_RAM   = 5'b01000,
		OP_LOAD_Y_CONST   = 5'b01001,
		OP_STORE_CONST    = 5'b01010,
		OP_LOAD_X_CONST   = 5'b01011,
		OP_SET_RAM_BIT    = 5'b01100,
		OP_CLEAR_RAM_BIT  = 5'b01101,
		OP_TEST_RAM_BIT   = 5'b01110,
		OP_COND_JUMP      = 5'b01111,
		OP_COND_CALL      = 5'b10000,
		OP_RETURN         = 5'b10001,
		OP_SET_PAGE       = 5'b10010,
		OP_SET_BLOCK      = 5'b10011,
		OP_TABLE_READ     = 5'b10100
	} nbx_op_t;

	typedef enum logic [0:0] {
		PH_RUN   = 1'b0,
		PH_TABLE = 1'b1
	} nbx_state_t;

endpackage : nbx_pkg

/* File: logic/nbx_pc_step.sv */
// pseudo-random word counter: xnor feedback so the all-zero reset word
// is a legal member of the sequence (all-ones is the locked state)
module nbx_pc_step #(
	parameter int W = 6
) (
	input  wire logic [W-1:0] pc,
	output logic      [W-1:0] pc_next
);

	assign pc_next = {pc[W-2:0], ~(pc[W-1] ^ pc[W-2])};

endmodule : nbx_pc_step

/* File: logic/nbx_core.sv */
module nbx_core #(
	parameter int STACK_DEPTH = nbx_pkg::STACK_D
) (
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic [7:0]            rom_data,
	output nbx_pkg::nbx_addr_t         rom_addr,
	output logic [nbx_pkg::NIB_W-1:0]  acc,
	output logic [nbx_pkg::NIB_W-1:0]  y_reg,
	output logic [nbx_pkg::X_W-1:0]    x_reg,
	output logic                       condition_flag,
	output logic [nbx_pkg::PAGE_W-1:0] current_page_reg,
	output logic [nbx_pkg::BLOCK_W-1:0] current_block,
	output logic [nbx_pkg::PAGE_W-1:0] next_page_latch,
	output logic [nbx_pkg::BLOCK_W-1:0] next_block_latch
);

	nbx_pkg::nbx_state_t          state_q;
	nbx_pkg::nbx_addr_t           fetch_q;
	nbx_pkg::nbx_addr_t           tbl_addr_q;
	nbx_pkg::nbx_addr_t           return_stack [STACK_DEPTH];
	nbx_pkg::nbx_addr_t           push_entry;
	nbx_pkg::nbx_op_t             op;
	logic [nbx_pkg::NIB_W-1:0]    acc_q;
	logic [nbx_pkg::NIB_W-1:0]    y_q;
	logic [nbx_pkg::X_W-1:0]      x_q;
	logic                         flag_q;
	logic [nbx_pkg::PAGE_W-1:0]   page_latch_q;
	logic [nbx_pkg::BLOCK_W-1:0]  block_latch_q;
	logic [nbx_pkg::NIB_W-1:0]    mem_q [2**nbx_pkg::RAM_AW];
	logic                         run;
	logic [nbx_pkg::PC_W-1:0]     pc_next;
	logic [nbx_pkg::RAM_AW-1:0]   ram_addr;
	logic [nbx_pkg::NIB_W-1:0]    ram_rd;
	logic [1:0]                   bit_sel;
	logic [nbx_pkg::NIB_W-1:0]    imm4;
	logic [nbx_pkg::PC_W-1:0]     imm6;
	logic                         call_taken;
	logic                         do_return;

	// the word counter steps through the pseudo-random sequence
	nbx_pc_step #(
		.W (nbx_pkg::PC_W)
	) i_nbx_pc_step (
		.pc      (fetch_q.pc),
		.pc_next (pc_next)
	);

	// operand fields and ram port, ram indexed by x then y
	assign run        = (state_q == nbx_pkg::PH_RUN);
	assign ram_addr   = {x_q, y_q};
	assign ram_rd     = mem_q[ram_addr];
	assign bit_sel    = rom_data[1:0];
	assign imm4       = rom_data[3:0];
	assign imm6       = rom_data[5:0];
	assign call_taken = (op == nbx_pkg::OP_COND_CALL) && flag_q;
	assign do_return  = (op == nbx_pkg::OP_RETURN);
	assign push_entry = '{block: fetch_q.block, page: fetch_q.page, pc: pc_next};

	// opcode decode; the second cycle of a table read decodes to no-op
	always_comb begin
		op = nbx_pkg::OP_NOP;
		if (!run) begin
			op = nbx_pkg::OP_NOP;
		end else if (rom_data[nbx_pkg::F4_HI:nbx_pkg::F4_LO] == nbx_pkg::OP4_JUMP) begin
			op = nbx_pkg::OP_COND_JUMP;
		end else if (rom_data[nbx_pkg::F4_HI:nbx_pkg::F4_LO] == nbx_pkg::OP4_CALL) begin
			op = nbx_pkg::OP_COND_CALL;
		end else if (rom_data[nbx_pkg::F3_HI:nbx_pkg::F3_LO] == nbx_pkg::OP3_LOAD_Y) begin
			op = nbx_pkg::OP_LOAD_Y_CONST;
		end else if (rom_data[nbx_pkg::F3_HI:nbx_pkg::F3_LO] == nbx_pkg::OP3_STORE_STEP) begin
			op = nbx_pkg::OP_STORE_CONST;
		end else if (rom_data[nbx_pkg::F3_HI:nbx_pkg::F3_LO] == nbx_pkg::OP3_SET_PAGE) begin
			op = nbx_pkg::OP_SET_PAGE;
		end else if (rom_data[nbx_pkg::F2_HI:nbx_pkg::F2_LO] == nbx_pkg::OP2_LOAD_X) begin
			op = nbx_pkg::OP_LOAD_X_CONST;
		end else if (rom_data[nbx_pkg::F2_HI:nbx_pkg::F2_LO] == nbx_pkg::OP2_SET_BIT) begin
			op = nbx_pkg::OP_SET_RAM_BIT;
		end else if (rom_data[nbx_pkg::F2_HI:nbx_pkg::F2_LO] == nbx_pkg::OP2_CLR_BIT) begin
			op = nbx_pkg::OP_CLEAR_RAM_BIT;
		end else if (rom_data[nbx_pkg::F2_HI:nbx_pkg::F2_LO] == nbx_pkg::OP2_TST_BIT) begin
			op = nbx_pkg::OP_TEST_RAM_BIT;
		end else begin
			case (rom_data)
				nbx_pkg::OP1_COPY_Y_TO_ACC:   op = nbx_pkg::OP_COPY_Y_TO_ACC;
				nbx_pkg::OP1_COPY_ACC_TO_Y:   op = nbx_pkg::OP_COPY_ACC_TO_Y;
				nbx_pkg::OP1_CLEAR_ACC:       op = nbx_pkg::OP_CLEAR_ACC;
				nbx_pkg::OP1_STORE_ACC:       op = nbx_pkg::OP_STORE_ACC;
				nbx_pkg::OP1_STORE_ACC_STEP:  op = nbx_pkg::OP_STORE_ACC_STEP;
				nbx_pkg::OP1_LOAD_Y_FROM_RAM: op = nbx_pkg::OP_LOAD_Y_RAM;
				nbx_pkg::OP1_LOAD_ACC_RAM:    op = nbx_pkg::OP_LOAD_ACC_RAM;
				nbx_pkg::OP1_SWAP_ACC_RAM:    op = nbx_pkg::OP_SWAP_ACC_RAM;
				nbx_pkg::OP1_RETURN:          op = nbx_pkg::OP_RETURN;
				nbx_pkg::OP1_SET_BLOCK_Y:     op = nbx_pkg::OP_SET_BLOCK;
				nbx_pkg::OP1_TABLE_READ:      op = nbx_pkg::OP_TABLE_READ;
				default:                      op = nbx_pkg::OP_NOP;
			endcase
		end
	end

	// accumulator and y; table read lands here in its second cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			acc_q <= nbx_pkg::RST_NIB;
			y_q   <= nbx_pkg::RST_NIB;
		end else if (!run) begin
			acc_q <= rom_data[7:4];
			y_q   <= rom_data[3:0];
		end else begin
			case (op)
				nbx_pkg::OP_COPY_Y_TO_ACC:  acc_q <= y_q;
				nbx_pkg::OP_COPY_ACC_TO_Y:  y_q <= acc_q;
				nbx_pkg::OP_CLEAR_ACC:      acc_q <= nbx_pkg::RST_NIB;
				nbx_pkg::OP_STORE_ACC_STEP: y_q <= y_q + 4'h1;
				nbx_pkg::OP_STORE_CONST:    y_q <= y_q + 4'h1;
				nbx_pkg::OP_LOAD_Y_RAM:     y_q <= ram_rd;
				nbx_pkg::OP_LOAD_ACC_RAM:   acc_q <= ram_rd;
				nbx_pkg::OP_SWAP_ACC_RAM:   acc_q <= ram_rd;
				nbx_pkg::OP_LOAD_Y_CONST:   y_q <= imm4;
				default: begin
				end
			endcase
		end
	end

	// ram page index
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			x_q <= nbx_pkg::RST_X;
		end else if (op == nbx_pkg::OP_LOAD_X_CONST) begin
			x_q <= bit_sel;
		end
	end

	// condition flag: every instruction here sets it except the bit test;
	// undefined opcodes leave it alone so they behave as no-ops
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flag_q <= nbx_pkg::RST_FLAG;
		end else if (!run) begin
			flag_q <= 1'b1;
		end else begin
			case (op)
				nbx_pkg::OP_TEST_RAM_BIT: flag_q <= ram_rd[bit_sel];
				nbx_pkg::OP_NOP:          flag_q <= flag_q;
				default:                  flag_q <= 1'b1;
			endcase
		end
	end

	// nibble ram; not reset, so software must write a word before reading it
	always_ff @(posedge clk) begin
		case (op)
			nbx_pkg::OP_STORE_ACC:      mem_q[ram_addr] <= acc_q;
			nbx_pkg::OP_STORE_ACC_STEP: mem_q[ram_addr] <= acc_q;
			nbx_pkg::OP_SWAP_ACC_RAM:   mem_q[ram_addr] <= acc_q;
			nbx_pkg::OP_STORE_CONST:    mem_q[ram_addr] <= imm4;
			nbx_pkg::OP_SET_RAM_BIT:    mem_q[ram_addr][bit_sel] <= 1'b1;
			nbx_pkg::OP_CLEAR_RAM_BIT:  mem_q[ram_addr][bit_sel] <= 1'b0;
			default: begin
			end
		endcase
	end

	// fetch address and latches; latches are only touched by their own
	// loads and by return, so a transfer stays in page by default
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fetch_q       <= '{block: nbx_pkg::RST_BLOCK, page: nbx_pkg::RST_PAGE, pc: '0};
			page_latch_q  <= nbx_pkg::RST_PAGE;
			block_latch_q <= nbx_pkg::RST_BLOCK;
		end else if (run) begin
			fetch_q.pc <= pc_next;
			case (op)
				nbx_pkg::OP_COND_JUMP, nbx_pkg::OP_COND_CALL: begin
					if (flag_q) begin
						fetch_q <= '{block: block_latch_q, page: page_latch_q, pc: imm6};
					end
				end
				nbx_pkg::OP_RETURN: begin
					fetch_q       <= return_stack[0];
					page_latch_q  <= return_stack[0].page;
					block_latch_q <= return_stack[0].block;
				end
				nbx_pkg::OP_SET_PAGE:  page_latch_q <= imm4;
				nbx_pkg::OP_SET_BLOCK: block_latch_q <= y_q[nbx_pkg::BLOCK_W-1:0];
				default: begin
				end
			endcase
		end
	end

	// return stack, one process per level; untaken calls never push
	for (genvar i = 0; i < STACK_DEPTH; i++) begin : g_stack
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				return_stack[i] <= '0;
			end else if (call_taken) begin
				if (i == 0) begin
					return_stack[i] <= push_entry;
				end else begin
					return_stack[i] <= return_stack[(i > 0) ? i - 1 : 0];
				end
			end else if (do_return) begin
				if (i < STACK_DEPTH - 1) begin
					return_stack[i] <= return_stack[(i < STACK_DEPTH - 1) ? i + 1 : i];
				end
			end
		end
	end

	// table read takes two cycles: the rom is shared with fetch
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q    <= nbx_pkg::PH_RUN;
			tbl_addr_q <= '0;
		end else begin
			case (state_q)
				nbx_pkg::PH_RUN: begin
					if (op == nbx_pkg::OP_TABLE_READ) begin
						state_q    <= nbx_pkg::PH_TABLE;
						tbl_addr_q <= {2'h0, x_q, acc_q, y_q};
					end
				end
				nbx_pkg::PH_TABLE: state_q <= nbx_pkg::PH_RUN;
				default:           state_q <= nbx_pkg::PH_RUN;
			endcase
		end
	end

	// outputs straight from the registers, except rom_addr: tbl_addr_q in a table read, else fetch_q
	assign rom_addr         = (state_q == nbx_pkg::PH_TABLE) ? tbl_addr_q : fetch_q;
	assign acc              = acc_q;
	assign y_reg            = y_q;
	assign x_reg            = x_q;
	assign condition_flag   = flag_q;
	assign current_page_reg = fetch_q.page;
	assign current_block    = fetch_q.block;
	assign next_page_latch  = page_latch_q;
	assign next_block_latch = block_latch_q;

	// checks of the instruction effects
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_copy_y;
		op == nbx_pkg::OP_COPY_Y_TO_ACC |=> acc_q == $past(y_q) && y_q == $past(y_q) && flag_q;
	endproperty
	a_copy_y: assert property (p_copy_y) else $error("copy y to acc wrong");

	property p_copy_acc;
		op == nbx_pkg::OP_COPY_ACC_TO_Y |=> y_q == $past(acc_q) && flag_q;
	endproperty
	a_copy_acc: assert property (p_copy_acc) else $error("copy acc to y wrong");

	property p_clear;
		op == nbx_pkg::OP_CLEAR_ACC |=> acc_q == 4'h0 && flag_q;
	endproperty
	a_clear: assert property (p_clear) else $error("clear acc wrong");

	property p_store_step;
		op == nbx_pkg::OP_STORE_ACC_STEP
			|=> y_q == 4'($past(y_q) + 4'h1) && acc_q == $past(acc_q)
			&& mem_q[$past(ram_addr)] == $past(acc_q);
	endproperty
	a_store_step: assert property (p_store_step) else $error("store step wrong");

	property p_swap;
		op == nbx_pkg::OP_SWAP_ACC_RAM
			|=> acc_q == $past(ram_rd) && mem_q[$past(ram_addr)] == $past(acc_q);
	endproperty
	a_swap: assert property (p_swap) else $error("swap wrong");

	property p_test_bit;
		op == nbx_pkg::OP_TEST_RAM_BIT |=> flag_q == $past(ram_rd[bit_sel]);
	endproperty
	a_test_bit: assert property (p_test_bit) else $error("bit test wrong");

	property p_jump_taken;
		op == nbx_pkg::OP_COND_JUMP && flag_q
			|=> fetch_q.pc == $past(imm6) && fetch_q.page == $past(page_latch_q)
			&& fetch_q.block == $past(block_latch_q);
	endproperty
	a_jump_taken: assert property (p_jump_taken) else $error("taken jump wrong");

	property p_call_skip;
		op == nbx_pkg::OP_COND_CALL && !flag_q
			|=> fetch_q.pc == $past(pc_next) && fetch_q.page == $past(fetch_q.page)
			&& fetch_q.block == $past(fetch_q.block)
			&& return_stack[0] == $past(return_stack[0]) && flag_q;
	endproperty
	a_call_skip: assert property (p_call_skip) else $error("untaken call wrong");

	property p_call_push;
		call_taken |=> return_stack[0] == $past(push_entry)
			&& return_stack[1] == $past(return_stack[0]);
	endproperty
	a_call_push: assert property (p_call_push) else $error("call push wrong");

	property p_return;
		do_return |=> fetch_q == $past(return_stack[0])
			&& page_latch_q == $past(return_stack[0].page)
			&& block_latch_q == $past(return_stack[0].block)
			&& return_stack[2] == $past(return_stack[2])
			&& return_stack[1] == $past(return_stack[2]);
	endproperty
	a_return: assert property (p_return) else $error("return wrong");

	property p_table;
		op == nbx_pkg::OP_TABLE_READ
			|=> state_q == nbx_pkg::PH_TABLE ##1 state_q == nbx_pkg::PH_RUN
			&& acc_q == $past(rom_data[7:4]) && y_q == $past(rom_data[3:0]);
	endproperty
	a_table: assert property (p_table) else $error("table read wrong");

	c_jump: cover property (op == nbx_pkg::OP_COND_JUMP && flag_q);
	c_call: cover property (call_taken ##[1:20] call_taken);
	c_return: cover property (do_return);
	c_table: cover property (state_q == nbx_pkg::PH_TABLE);

endmodule : nbx_core

/* File: dv/nbx_rom_model.sv */
// program rom seen by the core; the bench loads words by writing mem
// hierarchically, and unwritten words hold an undefined opcode (no-op)
module nbx_rom_model (
	input  wire nbx_pkg::nbx_addr_t addr,
	output logic [7:0]              data
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [7:0] mem [0:4095];

	// fill with a harmless opcode so a stray fetch never branches
	initial begin
		for (int k = 0; k < 4096; k++) begin
			mem[k] = 8'h1f;
		end
	end

	// combinational read, the core samples it on the next edge
	assign data = mem[addr];
endmodule : nbx_rom_model

/* File: dv/nbx_core_tb.sv */
module nbx_core_tb;
	timeunit 1ns;
	timeprecision 1ns;

	logic               clk;
	logic               rst;
	logic [7:0]         rom_data;
	nbx_pkg::nbx_addr_t rom_addr;
	logic [3:0]         acc;
	logic [3:0]         y_reg;
	logic [1:0]         x_reg;
	logic               condition_flag;
	logic [3:0]         current_page_reg;
	logic [1:0]         current_block;
	logic [3:0]         next_page_latch;
	logic [1:0]         next_block_latch;
	nbx_pkg::nbx_addr_t ea;
	nbx_pkg::nbx_addr_t r1;
	nbx_pkg::nbx_addr_t r2;
	nbx_pkg::nbx_addr_t r3;
	int                 fails;
	int                 n_tests;
	logic [7:0]         s_ops [9] = '{8'h00, 8'h01, 8'h02, 8'h05, 8'h06, 8'h09, 8'h21, 8'h4f, 8'h60};

	nbx_core i_nbx_core (.clk(clk), .rst(rst), .rom_data(rom_data), .rom_addr(rom_addr),
		.acc(acc), .y_reg(y_reg), .x_reg(x_reg), .condition_flag(condition_flag),
		.current_page_reg(current_page_reg), .current_block(current_block),
		.next_page_latch(next_page_latch), .next_block_latch(next_block_latch));

	nbx_rom_model i_nbx_rom_model (.addr(rom_addr), .data(rom_data));

	// 100 ns period clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// bench's own view of the word counter sequence
	function automatic logic [5:0] stp(input logic [5:0] pc);
		return {pc[4:0], ~(pc[5] ^ pc[4])};
	endfunction : stp

	task automatic cmp(input string what, input logic [11:0] e, input logic [11:0] g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask : cmp

	// data path registers and flag
	task automatic chk_reg(input logic [3:0] ea4, input logic [3:0] ey, input logic [1:0] ex2,
		input logic ef);
		cmp("acc", 12'(ea4), 12'(acc));
		cmp("y_reg", 12'(ey), 12'(y_reg));
		cmp("x_reg", 12'(ex2), 12'(x_reg));
		cmp("condition_flag", 12'(ef), 12'(condition_flag));
	endtask : chk_reg

	// latches, plus current page and block against the expected fetch address
	task automatic chk_lat(input logic [3:0] pl, input logic [1:0] bl);
		cmp("next_page_latch", 12'(pl), 12'(next_page_latch));
		cmp("next_block_latch", 12'(bl), 12'(next_block_latch));
		cmp("current_page_reg", 12'(ea.page), 12'(current_page_reg));
		cmp("current_block", 12'(ea.block), 12'(current_block));
	endtask : chk_lat

	// place one opcode at the expected fetch address, run it, check the next fetch
	task automatic ex(input logic [7:0] b, input logic tk = 1'b0,
		input nbx_pkg::nbx_addr_t tgt = '0);
		i_nbx_rom_model.mem[ea] = b;
		@(posedge clk);
		#1;
		if (tk) begin
			ea = tgt;
		end else begin
			ea.pc = stp(ea.pc);
		end
		cmp("rom_addr", 12'(ea), 12'(rom_addr));
	endtask : ex

	// two-cycle table read: opcode, then the data byte at the pointer
	task automatic tbl(input logic [7:0] d, input nbx_pkg::nbx_addr_t ptr);
		i_nbx_rom_model.mem[ea] = 8'h0a;
		@(posedge clk);
		#1;
		cmp("table_pointer", 12'(ptr), 12'(rom_addr));
		i_nbx_rom_model.mem[ptr] = d;
		@(posedge clk);
		#1;
		ea.pc = stp(ea.pc);
		cmp("rom_addr", 12'(ea), 12'(rom_addr));
	endtask : tbl

	// clear the flag by testing bit 0 of ram(0,0), which holds zero; x and y end at 0
	task automatic flag0();
		ex(8'h20);
		ex(8'h40);
		ex(8'h2c);
	endtask : flag0

	task automatic conclude();
		if (fails == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : conclude

	// hang guard: the sequence needs about 110 cycles, allow 2000
	initial begin
		#(100 * 2000);
		fails++;
		conclude();
	end

	initial begin
		fails = 0;
		n_tests = 0;
		ea = '0;
		rst = 1'b1;
		repeat (10) @(posedge clk);
		#1;
		rst = 1'b0;
		chk_reg(4'h0, 4'h0, 2'h0, 1'b1);
		chk_lat(4'h0, 2'h0);
		cmp("rom_addr", 12'(ea), 12'(rom_addr));
		// zero word at ram(0,0), then a failed bit test
		ex(8'h20);
		ex(8'h40);
		ex(8'h50);
		chk_reg(4'h0, 4'h1, 2'h0, 1'b1);
		flag0();
		chk_reg(4'h0, 4'h0, 2'h0, 1'b0);
		// each opcode in s_ops sets the flag from zero
		foreach (s_ops[k]) begin
			flag0();
			ex(s_ops[k]);
			cmp("condition_flag", 12'h001, 12'(condition_flag));
		end
		// store with step wraps y, then load back and work on bits
		ex(8'h21);
		ex(8'h4f);
		ex(8'h5a);
		chk_reg(4'h0, 4'h0, 2'h1, 1'b1);
		ex(8'h4f);
		ex(8'h06);
		chk_reg(4'ha, 4'hf, 2'h1, 1'b1);
		ex(8'h2c);
		chk_reg(4'ha, 4'hf, 2'h1, 1'b0);
		ex(8'h02);
		chk_reg(4'h0, 4'hf, 2'h1, 1'b1);
		ex(8'h24);
		ex(8'h06);
		chk_reg(4'hb, 4'hf, 2'h1, 1'b1);
		ex(8'h29);
		ex(8'h2d);
		chk_reg(4'hb, 4'hf, 2'h1, 1'b0);
		ex(8'h2f);
		ex(8'h06);
		chk_reg(4'h9, 4'hf, 2'h1, 1'b1);
		// copies and swap
		ex(8'h43);
		ex(8'h00);
		chk_reg(4'h3, 4'h3, 2'h1, 1'b1);
		ex(8'h4f);
		ex(8'h07);
		chk_reg(4'h9, 4'hf, 2'h1, 1'b1);
		ex(8'h01);
		chk_reg(4'h9, 4'h9, 2'h1, 1'b1);
		ex(8'h4f);
		ex(8'h05);
		chk_reg(4'h9, 4'h3, 2'h1, 1'b1);
		// accumulator stores, plain and stepping
		ex(8'h22);
		ex(8'h47);
		ex(8'h04);
		chk_reg(4'h9, 4'h8, 2'h2, 1'b1);
		ex(8'h02);
		ex(8'h03);
		chk_reg(4'h0, 4'h8, 2'h2, 1'b1);
		ex(8'h47);
		ex(8'h06);
		chk_reg(4'h9, 4'h7, 2'h2, 1'b1);
		ex(8'h48);
		ex(8'h05);
		chk_reg(4'h9, 4'h0, 2'h2, 1'b1);
		// untaken jump steps and sets the flag
		flag0();
		ex(8'h95);
		chk_reg(4'h9, 4'h0, 2'h0, 1'b1);
		// latches first, then a long jump
		ex(8'h42);
		ex(8'h09);
		ex(8'h65);
		chk_lat(4'h5, 2'h2);
		chk_reg(4'h9, 4'h2, 2'h0, 1'b1);
		ex(8'h91, 1'b1, '{2'h2, 4'h5, 6'h11});
		// three nested calls, the last one long into another block
		r1 = ea;
		r1.pc = stp(ea.pc);
		ex(8'he0, 1'b1, '{2'h2, 4'h5, 6'h20});
		ex(8'h63);
		r2 = ea;
		r2.pc = stp(ea.pc);
		ex(8'hf0, 1'b1, '{2'h2, 4'h3, 6'h30});
		ex(8'h41);
		ex(8'h09);
		ex(8'h67);
		r3 = ea;
		r3.pc = stp(ea.pc);
		ex(8'hc5, 1'b1, '{2'h1, 4'h7, 6'h05});
		chk_lat(4'h7, 2'h1);
		// untaken call: no push, same page and block
		flag0();
		ex(8'hc9);
		chk_reg(4'h9, 4'h0, 2'h0, 1'b1);
		chk_lat(4'h7, 2'h1);
		// unwind; a fourth return finds the bottom level kept
		ex(8'h08, 1'b1, r3);
		chk_lat(r3.page, r3.block);
		ex(8'h08, 1'b1, r2);
		chk_lat(r2.page, r2.block);
		ex(8'h08, 1'b1, r1);
		ex(8'h08, 1'b1, r1);
		chk_lat(r1.page, r1.block);
		// table read at {x, acc, y} = {3, 6, 9}
		ex(8'h46);
		ex(8'h00);
		ex(8'h49);
		ex(8'h23);
		tbl(8'hc4, '{2'h0, 4'hd, 6'h29});
		chk_reg(4'hc, 4'h4, 2'h3, 1'b1);
		conclude();
	end
endmodule : nbx_core_tb
